// ### rtl/acs_pkg.sv
// Constants, register map and types shared by the conversion sequencer.
// Assumes a single 125 MHz clock that also serves as the oscillator period.
package acs_pkg;

	////////////////////////////////////////////////////////////////////////
	// Clock and timing
	localparam int CLK_PERIOD_NS   = 8;                           // Clock period
	localparam int RC_TAD_NS       = 1200;                        // Internal RC bit period
	localparam int RC_TAD_CYCLES   = RC_TAD_NS / CLK_PERIOD_NS;   // RC period in cycles
	localparam int TCY_OSC         = 4;                           // Oscillator periods per instr
	localparam int CONV_TADS       = 11;                          // Bit periods per conversion
	localparam int WAIT_TADS       = 2;                           // Wait after end or abort
	localparam int STRAP_SETTLE    = 3;                           // Cycles before strap capture

	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL0   = 8'h00;  // On, start/busy, channel
	localparam logic [7:0] OFS_CTRL1   = 8'h04;  // Port configuration
	localparam logic [7:0] OFS_CTRL2   = 8'h08;  // Format, acquisition, clock
	localparam logic [7:0] OFS_RES_HI  = 8'h0c;  // Result high byte
	localparam logic [7:0] OFS_RES_LO  = 8'h10;  // Result low byte
	localparam logic [7:0] OFS_STATUS  = 8'h14;  // Done flag, phase
	localparam logic [7:0] OFS_PORT    = 8'h18;  // Digital port read
	localparam logic [7:0] OFS_TRIGCFG = 8'h1c;  // Compare unit 2 mode

	////////////////////////////////////////////////////////////////////////
	// Field positions
	localparam int BIT_ON      = 0;  // CTRL0 converter_on
	localparam int BIT_BUSY    = 1;  // CTRL0 start/busy
	localparam int POS_CHAN    = 2;  // CTRL0 channel_select lsb
	localparam int BIT_FMT     = 7;  // CTRL2 result_format
	localparam int POS_ACQ     = 3;  // CTRL2 acq_time_select lsb
	localparam int POS_CSEL    = 0;  // CTRL2 conv_clock_select lsb
	localparam int BIT_DONE    = 0;  // STATUS conv_done_flag
	localparam int POS_PHASE   = 4;  // STATUS phase lsb

	////////////////////////////////////////////////////////////////////////
	// Values
	localparam int          NUM_PINS       = 13;       // Analog capable pins
	localparam logic [3:0]  TRIG_MODE      = 4'hb;     // Special event trigger mode
	localparam logic [3:0]  PORT_CONFIG_FIELD_ANALOG    = 4'h0;     // Second port analog at reset
	localparam logic [3:0]  PORT_CONFIG_FIELD_DIGITAL   = 4'h7;     // Second port digital at reset
	localparam logic [9:0]  SAR_MSB        = 10'h200;  // First trial bit
	localparam logic [31:0] RD_UNMAPPED    = 32'h0;    // Unmapped read value

	////////////////////////////////////////////////////////////////////////
	// Sequencer phases
	typedef enum logic [2:0] {
		ACS_OFF    = 3'b000,
		ACS_SAMPLE = 3'b001,
		ACS_DELAY  = 3'b010,
		ACS_ACQ    = 3'b011,
		ACS_CONV   = 3'b100,
		ACS_WAIT   = 3'b101
	} acs_phase_type;

	// Acquisition bit periods per select code
	function automatic logic [4:0] acs_acq_tads(input logic [2:0] sel);
		logic [4:0] r;
		r = 5'd0;
		case (sel)
			3'b000:  r = 5'd0;
			3'b001:  r = 5'd2;
			3'b010:  r = 5'd4;
			3'b011:  r = 5'd6;
			3'b100:  r = 5'd8;
			3'b101:  r = 5'd12;
			3'b110:  r = 5'd16;
			default: r = 5'd20;
		endcase
		return r;
	endfunction

endpackage

// ### rtl/acs_sequencer.sv
// Conversion sequencer for a 10-bit successive approximation converter.
// Assumes an Avalon-MM master on clock_in, a comparator and pins on
// asynchronous inputs, and direction and latch bits from port logic.
//
// Summary of operation
// RULE1 - Conversion lasts eleven bit periods
// RULE2 - Clock select gives divider or RC period
// RULE3 - Software picks shortest legal bit period
// RULE4 - RC above 1 MHz needs Sleep
// RULE5 - Update timing fields for power modes
// RULE6 - Keep system clock until conversion ends
// RULE7 - Use RC clock below 1 MHz
// RULE8 - Use RC clock for Sleep conversions
// RULE9 - Zero acquisition delays start one instruction
// RULE10 - Clear idle enable before Sleep conversion
// RULE11 - Output pin converts its driven level
// RULE12 - Sequence independent of channel and direction
// RULE13 - Analog pins read zero on port
// RULE14 - Digital inputs remain convertible
// RULE15 - Strap sets port config reset value
// RULE16 - Code 010 samples four periods first
// RULE17 - Clearing busy aborts, result kept
// RULE18 - Wait two periods then resume sampling
// RULE19 - Never start in the power-on write
// RULE20 - Discharge array before every sample
// RULE21 - Trigger starts conversion, clears timer
// RULE22 - Trigger ignored when off, timer cleared
// RULE23 - Completion loads result, clears busy, flags
// RULE24 - Acquisition codes map zero to twenty
// RULE25 - Format bit selects right or left
// RULE26 - Busy reads one until end or abort
//
// Local design decisions: the address map and register access over Avalon-MM.
`timescale 1ns/10ps
module acs_sequencer (
	// Clock and reset
	input  wire logic                           clock_in,
	input  wire logic                           srst_in,
	// Avalon-MM slave
	input  wire logic [7:0]                     avs_address_in,
	input  wire logic                           avs_read_in,
	input  wire logic                           avs_write_in,
	input  wire logic [31:0]                    avs_writedata_in,
	output logic [31:0]                         avs_readdata_out,
	output logic                                avs_waitrequest_out,
	// Analog front end
	input  wire logic                           comp_in,
	output logic [9:0]                          dac_code_out,
	output logic [3:0]                          mux_channel_out,
	output logic                                sample_switch_out,
	output logic                                discharge_out,
	// Pins and port logic
	input  wire logic [acs_pkg::NUM_PINS-1:0]   pin_level_in,
	input  wire logic [acs_pkg::NUM_PINS-1:0]   pin_direction_in,
	input  wire logic [acs_pkg::NUM_PINS-1:0]   pin_out_latch_in,
	input  wire logic                           portb_analog_reset_cfg_in,
	// Compare unit 2 trigger
	input  wire logic                           trigger_in,
	output logic                                timer_clear_out,
	// Status
	output logic                                busy_out,
	output logic                                conv_done_flag_out
);
	import acs_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		acs_phase_type          phase;      // Sequencer phase
		logic                   on;         // converter_on
		logic                   busy;       // start/busy
		logic [3:0]             chan;       // channel_select
		logic [3:0]             port_config_field;       // port_config_field
		logic                   fmt;        // result_format
		logic [2:0]             acq;        // acq_time_select
		logic [2:0]             csel;       // conv_clock_select
		logic [3:0]             ccp_mode;   // compare2_mode
		logic [7:0]             res_hi;     // result_high
		logic [7:0]             res_lo;     // result_low
		logic                   done;       // conv_done_flag
		logic [4:0]             tcnt;       // Bit periods in phase
		logic [2:0]             dcnt;       // Delay cycles
		logic [9:0]             sar;        // Trial code
		logic                   ack;        // Bus answer cycle
		logic [31:0]            rdata;      // Read data
		logic                   tclr;       // Timer clear pulse
		logic [1:0]             strap_cnt;  // Strap capture countdown
		logic                   comp_s1;    // Comparator sync stage 1
		logic                   comp_s2;    // Comparator sync stage 2
		logic                   strap_s1;   // Strap sync stage 1
		logic                   strap_s2;   // Strap sync stage 2
		logic [NUM_PINS-1:0]    pins_s1;    // Pin sync stage 1
		logic [NUM_PINS-1:0]    pins_s2;    // Pin sync stage 2
	} acs_state_type;

	acs_state_type       s;            // Registered state
	acs_state_type       next_s;       // Next state
	logic                tick;         // Bit period enable
	logic                restart;      // Phase change realigns period
	logic [NUM_PINS-1:0] analog_mask;  // Pins set to analog
	logic [3:0]          analog_cnt;   // Number of analog pins

	////////////////////////////////////////////////////////////////////////
	// Bit period generator
	// RULE2 - divided period select
	acs_tick u_tick (
		.clock_in        (clock_in),
		.srst_in         (srst_in),
		.restart_in      (restart),
		.clock_select_in (s.csel),
		.tick_out        (tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Analog pin mask from port configuration
	always_comb begin
		if (s.port_config_field <= 4'h2) begin
			analog_cnt = 4'(NUM_PINS);
		end else begin
			analog_cnt = 4'hf - s.port_config_field;
		end
	end

	// Per pin analog decision
	for (genvar g = 0; g < NUM_PINS; g++) begin : g_mask
		assign analog_mask[g] = (4'(g) < analog_cnt);
	end

	////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		logic        req;        // Request present
		logic        wr;         // Write takes effect
		logic        start_req;  // Start request
		logic        abort_req;  // Abort request
		logic        cmp;        // Decision input
		logic [9:0]  m;          // Current trial bit
		logic [9:0]  fin;        // Finished code
		logic [4:0]  acq_tads;   // Acquisition periods
		req = avs_read_in | avs_write_in;
		wr = avs_write_in & s.ack;
		start_req = 1'b0;
		abort_req = 1'b0;
		cmp = 1'b0;
		m = 10'h0;
		fin = 10'h0;
		acq_tads = acs_acq_tads(s.acq);
		next_s = s;
		next_s.tclr = 1'b0;
		// Answer one cycle after the request appears
		next_s.ack = req & ~s.ack;

		// Synchronisers
		next_s.comp_s1 = comp_in;
		next_s.comp_s2 = s.comp_s1;
		next_s.strap_s1 = portb_analog_reset_cfg_in;
		next_s.strap_s2 = s.strap_s1;
		next_s.pins_s1 = pin_level_in;
		next_s.pins_s2 = s.pins_s1;

		// RULE15 - strap capture after release
		if (s.strap_cnt != 2'd0) begin
			next_s.strap_cnt = s.strap_cnt - 2'd1;
			if (s.strap_cnt == 2'd1) begin
				next_s.port_config_field = s.strap_s2 ? PORT_CONFIG_FIELD_ANALOG : PORT_CONFIG_FIELD_DIGITAL;
			end
		end

		// Read data, latched on the request cycle
		if (avs_read_in & ~s.ack) begin
			case (avs_address_in)
				OFS_CTRL0: begin
					// RULE26 - busy visible to polling
					next_s.rdata = {26'h0, s.chan, s.busy, s.on};
				end
				OFS_CTRL1:   next_s.rdata = {28'h0, s.port_config_field};
				OFS_CTRL2:   next_s.rdata = {24'h0, s.fmt, 1'b0, s.acq, s.csel};
				OFS_RES_HI:  next_s.rdata = {24'h0, s.res_hi};
				OFS_RES_LO:  next_s.rdata = {24'h0, s.res_lo};
				OFS_STATUS:  next_s.rdata = {25'h0, s.phase, 3'h0, s.done};
				OFS_PORT: begin
					// RULE13 - analog pins read zero
					next_s.rdata = {19'h0, s.pins_s2 & ~analog_mask};
				end
				OFS_TRIGCFG: next_s.rdata = {28'h0, s.ccp_mode};
				default:     next_s.rdata = RD_UNMAPPED;
			endcase
		end

		// Register writes
		if (wr) begin
			case (avs_address_in)
				OFS_CTRL0: begin
					next_s.on = avs_writedata_in[BIT_ON];
					next_s.chan = avs_writedata_in[POS_CHAN +: 4];
					// Start only when already on and idle
					if (avs_writedata_in[BIT_BUSY] & s.on & ~s.busy) begin
						start_req = 1'b1;
					end
					// RULE17 - clearing busy aborts
					if (~avs_writedata_in[BIT_BUSY] & s.busy) begin
						abort_req = 1'b1;
					end
				end
				OFS_CTRL1:   next_s.port_config_field = avs_writedata_in[3:0];
				OFS_CTRL2: begin
					next_s.fmt = avs_writedata_in[BIT_FMT];
					next_s.acq = avs_writedata_in[POS_ACQ +: 3];
					next_s.csel = avs_writedata_in[POS_CSEL +: 3];
				end
				OFS_RES_HI:  next_s.res_hi = avs_writedata_in[7:0];
				OFS_RES_LO:  next_s.res_lo = avs_writedata_in[7:0];
				OFS_STATUS: begin
					// Write one clears the done flag
					if (avs_writedata_in[BIT_DONE]) begin
						next_s.done = 1'b0;
					end
				end
				OFS_TRIGCFG: next_s.ccp_mode = avs_writedata_in[3:0];
				default: begin
					// Unmapped writes are dropped
				end
			endcase
		end

		// RULE21 - special event trigger
		if (trigger_in && (s.ccp_mode == TRIG_MODE)) begin
			// RULE22 - timer cleared even when off
			next_s.tclr = 1'b1;
			if (s.on & ~s.busy) begin
				start_req = 1'b1;
			end
		end

		// RULE11 - output pin converts driven level
		if ((s.chan < 4'(NUM_PINS)) && !pin_direction_in[s.chan]) begin
			cmp = pin_out_latch_in[s.chan];
		end else begin
			// RULE14 - digital inputs still converted
			cmp = s.comp_s2;
		end

		// RULE12 - same sequence for every channel
		case (s.phase)
			ACS_OFF: begin
				next_s.busy = 1'b0;
				if (next_s.on) begin
					// RULE20 - discharge before first sample
					next_s.phase = ACS_WAIT;
					next_s.tcnt = 5'd0;
				end
			end
			ACS_SAMPLE: begin
				if (start_req) begin
					next_s.busy = 1'b1;
					if (acq_tads == 5'd0) begin
						// RULE9 - one instruction delay
						next_s.phase = ACS_DELAY;
						next_s.dcnt = 3'd0;
					end else begin
						next_s.phase = ACS_ACQ;
						next_s.tcnt = 5'd0;
					end
				end
			end
			ACS_DELAY: begin
				if (s.dcnt == 3'(TCY_OSC - 1)) begin
					next_s.phase = ACS_CONV;
					next_s.tcnt = 5'd0;
					next_s.sar = 10'h0;
				end else begin
					next_s.dcnt = s.dcnt + 3'd1;
				end
			end
			ACS_ACQ: begin
				if (tick) begin
					// RULE16 - programmed acquisition length
					// RULE24 - code to period mapping
					if (s.tcnt == acq_tads - 5'd1) begin
						next_s.phase = ACS_CONV;
						next_s.tcnt = 5'd0;
						next_s.sar = 10'h0;
					end else begin
						next_s.tcnt = s.tcnt + 5'd1;
					end
				end
			end
			ACS_CONV: begin
				if (tick) begin
					if (s.tcnt == 5'd0) begin
						next_s.sar = SAR_MSB;
					end else begin
						m = SAR_MSB >> (s.tcnt - 5'd1);
						fin = cmp ? s.sar : (s.sar & ~m);
						next_s.sar = fin | (m >> 1);
					end
					// RULE1 - eleven bit periods
					if (s.tcnt == 5'(CONV_TADS - 1)) begin
						// RULE23 - load result, clear busy
						next_s.sar = fin;
						next_s.busy = 1'b0;
						next_s.done = 1'b1;
						next_s.phase = ACS_WAIT;
						next_s.tcnt = 5'd0;
						// RULE25 - right or left justified
						if (s.fmt) begin
							next_s.res_hi = {6'h0, fin[9:8]};
							next_s.res_lo = fin[7:0];
						end else begin
							next_s.res_hi = fin[9:2];
							next_s.res_lo = {fin[1:0], 6'h0};
						end
					end else begin
						next_s.tcnt = s.tcnt + 5'd1;
					end
				end
			end
			ACS_WAIT: begin
				// RULE18 - two period wait then sample
				if (tick) begin
					if (s.tcnt == 5'(WAIT_TADS - 1)) begin
						next_s.phase = ACS_SAMPLE;
					end else begin
						next_s.tcnt = s.tcnt + 5'd1;
					end
				end
			end
			default: begin
				next_s.phase = ACS_OFF;
			end
		endcase

		// Abort keeps result, goes to wait
		if (abort_req && (s.phase == ACS_DELAY || s.phase == ACS_ACQ ||
		                  s.phase == ACS_CONV)) begin
			next_s.busy = 1'b0;
			next_s.phase = ACS_WAIT;
			next_s.tcnt = 5'd0;
		end

		// Switching off stops everything
		if (!next_s.on) begin
			next_s.busy = 1'b0;
			next_s.phase = ACS_OFF;
		end
	end

	// Phase change realigns the bit period
	assign restart = (next_s.phase != s.phase);

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			s <= '0;
			s.strap_cnt <= 2'(STRAP_SETTLE);
		end else begin
			s <= next_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~s.ack;
	assign avs_readdata_out = s.rdata;
	assign dac_code_out = s.sar;
	assign mux_channel_out = s.chan;
	assign sample_switch_out = (s.phase == ACS_SAMPLE) || (s.phase == ACS_ACQ) ||
	                           (s.phase == ACS_DELAY);
	// RULE20 - array discharged in wait phase
	assign discharge_out = (s.phase == ACS_WAIT);
	assign timer_clear_out = s.tclr;
	assign busy_out = s.busy;
	assign conv_done_flag_out = s.done;

endmodule

// ### rtl/acs_tick.sv
// Bit period enable generator for the conversion sequencer.
// Assumes restart is a same-clock pulse from the sequencer.
`timescale 1ns/10ps
module acs_tick (
	// Clock and reset
	input  wire logic       clock_in,
	input  wire logic       srst_in,
	// Control
	input  wire logic       restart_in,
	input  wire logic [2:0] clock_select_in,
	// Bit period enable
	output logic            tick_out
);
	import acs_pkg::*;

	typedef struct packed {
		logic [7:0] cnt;   // Cycles into period
		logic       tick;  // Period end pulse
	} acs_tick_state_type;

	acs_tick_state_type s;       // Registered state
	acs_tick_state_type next_s;  // Next state
	logic [7:0]         last;    // Final count of a period

	////////////////////////////////////////////////////////////////////////
	// Period length per select code
	always_comb begin
		case (clock_select_in)
			3'b000:  last = 8'd1;
			3'b100:  last = 8'd3;
			3'b001:  last = 8'd7;
			3'b101:  last = 8'd15;
			3'b010:  last = 8'd31;
			3'b110:  last = 8'd63;
			default: last = 8'(RC_TAD_CYCLES - 1);
		endcase
	end

	// Counter and pulse
	always_comb begin
		next_s = s;
		next_s.tick = 1'b0;
		if (restart_in) begin
			next_s.cnt = 8'd0;
		end else if (s.cnt >= last) begin
			next_s.cnt = 8'd0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + 8'd1;
		end
	end

	// State register
	always_ff @(posedge clock_in) begin
		if (srst_in) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tick_out = s.tick;

endmodule

// ### test/acs_afe_model.sv
// Analog front end model: comparator against a held input level.
// Assumes the level is a whole code; the input counts as above at equality.
`timescale 1ns/10ps
module acs_afe_model (
	// Converter side
	input  wire logic [9:0] dac_code_in,
	input  wire logic [9:0] level_in,
	output logic            comp_out
);
	// Comparator settles at once; the block synchronises it
	assign comp_out = (level_in >= dac_code_in);
endmodule

// ### test/acs_sequencer_properties.sv
// Port-level assertions for the conversion sequencer.
// Assumes one clock domain and the synchronous reset of the block.
`timescale 1ns/10ps
module acs_seq_chk
	import acs_pkg::*;
(
	// Clock and reset
	input  wire logic        clock_in,
	input  wire logic        srst_in,
	// Bus request side
	input  wire logic [7:0]  avs_address_in,
	input  wire logic        avs_write_in,
	input  wire logic [31:0] avs_writedata_in,
	input  wire logic        avs_waitrequest_out,
	// Sequencer observables
	input  wire logic        trigger_in,
	input  wire logic        timer_clear_out,
	input  wire logic        busy_out,
	input  wire logic        conv_done_flag_out,
	input  wire logic        discharge_out,
	input  wire logic        sample_switch_out
);
	////////////////////////////////////////////////////////////////////////
	// Decoded bus writes taken by the block
	logic ctl_wr;    // Control write accepted
	logic start_wr;  // Control write asking for a start
	logic clr_wr;    // Done clear accepted
	assign ctl_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == OFS_CTRL0;
	assign start_wr = ctl_wr && avs_writedata_in[BIT_BUSY];
	assign clr_wr = avs_write_in && !avs_waitrequest_out && avs_address_in == OFS_STATUS
		&& avs_writedata_in[BIT_DONE];

	default clocking @(posedge clock_in); endclocking
	default disable iff (srst_in);

	////////////////////////////////////////////////////////////////////////
	// Trigger and timer clear
	chk_clear_pulse:
		assert property (timer_clear_out |=> !timer_clear_out) else $error("clear too long");
	chk_clear_cause:
		assert property (timer_clear_out |-> $past(trigger_in)) else $error("clear w/o trigger");
	// Busy and done
	chk_busy_start:
		assert property ($rose(busy_out) |-> $past(start_wr) || $past(trigger_in))
		else $error("busy rose without start");
	chk_busy_fall:
		assert property ($fell(busy_out) |-> $past(ctl_wr) || conv_done_flag_out)
		else $error("busy fell without cause");
	chk_done_end:
		assert property ($rose(conv_done_flag_out) |-> $fell(busy_out))
		else $error("done without completion");
	chk_done_sticky:
		assert property (conv_done_flag_out && !clr_wr |=> conv_done_flag_out)
		else $error("done flag lost");
	// Wait and discharge
	chk_wait_after:
		assert property ($fell(busy_out) |-> ##[0:2] discharge_out [*2])
		else $error("no wait after end");
	chk_discharge_first:
		assert property ($rose(sample_switch_out) |-> $past(discharge_out))
		else $error("sample without discharge");
endmodule

bind acs_sequencer acs_seq_chk u_chk (.clock_in, .srst_in, .avs_address_in, .avs_write_in,
	.avs_writedata_in, .avs_waitrequest_out, .trigger_in, .timer_clear_out, .busy_out,
	.conv_done_flag_out, .discharge_out, .sample_switch_out);

// ### test/acs_sequencer_tb_top.sv
// Self-checking bench for the conversion sequencer.
// Assumes the front end model and the bound property checker.
`timescale 1ns/10ps
`define CHECK(nm, ex, got) begin checks++; if ((got) !== (ex)) begin n_mismatch++; \
	$display("wrong value %s expected %0h seen %0h", nm, ex, got); end end
module acs_sequencer_tb_top;
	import acs_pkg::*;
	////////////////////////////////////////////////////////////////////////
	// Signals
	logic                clock_in, srst_in, avs_read_in, avs_write_in, comp_in;
	logic                strap, trigger_in, avs_waitrequest_out, sample_switch_out;
	logic                discharge_out, timer_clear_out, busy_out, conv_done_flag_out;
	logic [7:0]          avs_address_in;
	logic [31:0]         avs_writedata_in, avs_readdata_out, q;
	logic [9:0]          dac_code_out, level;
	logic [3:0]          mux_channel_out;
	logic [NUM_PINS-1:0] pin_dir;
	logic [2:0]          sels [8] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6, 3'h3, 3'h7};
	int                  per [8] = '{2, 8, 32, RC_TAD_CYCLES, 4, 16, 64, RC_TAD_CYCLES};
	int                  acq_t [8] = '{0, 2, 4, 6, 8, 12, 16, 20};
	int                  n_mismatch, checks, cyc;

	acs_sequencer DUT (.clock_in(clock_in), .srst_in(srst_in), .avs_address_in(avs_address_in),
		.avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
		.avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
		.avs_waitrequest_out(avs_waitrequest_out), .comp_in(comp_in),
		.dac_code_out(dac_code_out), .mux_channel_out(mux_channel_out),
		.sample_switch_out(sample_switch_out), .discharge_out(discharge_out),
		.pin_level_in('1), .pin_direction_in(pin_dir), .pin_out_latch_in('1),
		.portb_analog_reset_cfg_in(strap), .trigger_in(trigger_in),
		.timer_clear_out(timer_clear_out), .busy_out(busy_out),
		.conv_done_flag_out(conv_done_flag_out));
	acs_afe_model u_afe (.dac_code_in(dac_code_out), .level_in(level), .comp_out(comp_in));

	// Free running 125 MHz clock
	initial begin
		clock_in = 1'b0;
		forever #4 clock_in = ~clock_in;
	end
	// Hang guard
	always @(posedge clock_in) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			complete_run();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bus access: hold until waitrequest seen low, take data there
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clock_in);
		avs_address_in <= a;
		avs_writedata_in <= d;
		avs_write_in <= w;
		avs_read_in <= !w;
		@(posedge clock_in);
		while (avs_waitrequest_out !== 1'b0 && n < 20) begin
			@(posedge clock_in);
			n++;
		end
		q = avs_readdata_out;
		avs_write_in <= 1'b0;
		avs_read_in <= 1'b0;
		`CHECK("bus answer", 1'b1, 1'(n < 20))
	endtask
	// Bounded wait on a block output, and a one-cycle trigger pulse
	task automatic wait_sample(output int n);
		n = 0;
		while (sample_switch_out !== 1'b1 && n < 600) begin
			@(negedge clock_in);
			n++;
		end
	endtask
	task automatic pulse();
		@(posedge clock_in);
		trigger_in <= 1'b1;
		@(posedge clock_in);
		trigger_in <= 1'b0;
		@(negedge clock_in);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Reset with a strap value, reset values and unmapped read
	task automatic t_reset(input logic s);
		srst_in <= 1'b1;
		strap <= s;
		repeat (4) @(posedge clock_in);
		srst_in <= 1'b0;
		repeat (4) @(posedge clock_in);
		`CHECK("busy", 1'b0, busy_out)
		bus(1'b0, OFS_CTRL1, 32'h0);
		`CHECK("port config", s ? PORT_CONFIG_FIELD_ANALOG : PORT_CONFIG_FIELD_DIGITAL, q[3:0])
		bus(1'b0, 8'h20, 32'h0);
		`CHECK("unmapped", RD_UNMAPPED, q)
		$display("test reset done");
	endtask
	// Port reads with analog pins masked
	task automatic t_port();
		bus(1'b1, OFS_CTRL1, 32'h0);
		bus(1'b0, OFS_PORT, 32'h0);
		`CHECK("port all analog", 13'h0, q[12:0])
		bus(1'b1, OFS_CTRL1, 32'hd);
		bus(1'b0, OFS_PORT, 32'h0);
		`CHECK("port two analog", 13'h1ffc, q[12:0])
		bus(1'b1, OFS_CTRL1, 32'hf);
		bus(1'b0, OFS_PORT, 32'h0);
		`CHECK("port digital", 13'h1fff, q[12:0])
		$display("test port done");
	endtask
	// One conversion: timing, channel, busy and justified result
	task automatic t_conv(input logic [2:0] s, input logic [2:0] a, input logic f,
		input logic [3:0] ch, input logic drv, input logic [9:0] lv);
		int n;
		int ex;
		logic [9:0] r;
		ex = (acq_t[a] + CONV_TADS) * per[s] + (a == 3'h0 ? TCY_OSC : 0) + 1;
		r = drv ? 10'h3ff : lv;
		level <= lv;
		pin_dir <= ~(NUM_PINS'(drv) << ch);
		bus(1'b1, OFS_CTRL2, {24'h0, f, 1'b0, a, s});
		bus(1'b1, OFS_CTRL0, {26'h0, ch, 2'b01});
		bus(1'b1, OFS_STATUS, 32'h1);
		wait_sample(n);
		bus(1'b1, OFS_CTRL0, {26'h0, ch, 2'b11});
		n = 0;
		while (conv_done_flag_out !== 1'b1 && n < 6000) begin
			@(negedge clock_in);
			n++;
			if (n == 2) begin
				`CHECK("busy held", 1'b1, busy_out)
				`CHECK("channel", ch, mux_channel_out)
			end
		end
		`CHECK("conv length", 1'b1, 1'(n >= ex - 2 && n <= ex + 2))
		`CHECK("busy end", 1'b0, busy_out)
		bus(1'b0, OFS_RES_HI, 32'h0);
		`CHECK("result high", f ? {6'h0, r[9:8]} : r[9:2], q[7:0])
		bus(1'b0, OFS_RES_LO, 32'h0);
		`CHECK("result low", f ? r[7:0] : {r[1:0], 6'h0}, q[7:0])
		$display("test conv %0d done", a);
	endtask
	// Abort keeps the stored result, then wait and resample
	task automatic t_abort();
		int n;
		bus(1'b1, OFS_CTRL2, 32'h6);
		bus(1'b1, OFS_RES_LO, 32'h5a);
		bus(1'b1, OFS_STATUS, 32'h1);
		wait_sample(n);
		bus(1'b1, OFS_CTRL0, 32'h3);
		repeat (200) @(posedge clock_in);
		bus(1'b1, OFS_CTRL0, 32'h1);
		@(negedge clock_in);
		`CHECK("busy abort", 1'b0, busy_out)
		`CHECK("done abort", 1'b0, conv_done_flag_out)
		wait_sample(n);
		`CHECK("wait length", 1'b1, 1'(n >= 125 && n <= 131))
		bus(1'b0, OFS_RES_LO, 32'h0);
		`CHECK("kept result", 8'h5a, q[7:0])
		$display("test abort done");
	endtask
	// Trigger start, trigger while off, other mode, start with power on
	task automatic t_trig();
		int n;
		bus(1'b1, OFS_TRIGCFG, {28'h0, TRIG_MODE});
		bus(1'b1, OFS_CTRL2, 32'hc);
		bus(1'b1, OFS_STATUS, 32'h1);
		pulse();
		`CHECK("timer clear", 1'b1, timer_clear_out)
		`CHECK("trigger busy", 1'b1, busy_out)
		n = 0;
		while (conv_done_flag_out !== 1'b1 && n < 1000) begin
			@(negedge clock_in);
			n++;
		end
		`CHECK("trigger done", 1'b1, conv_done_flag_out)
		bus(1'b1, OFS_CTRL0, 32'h0);
		pulse();
		`CHECK("clear when off", 1'b1, timer_clear_out)
		`CHECK("busy when off", 1'b0, busy_out)
		bus(1'b1, OFS_TRIGCFG, 32'h0);
		pulse();
		`CHECK("clear other mode", 1'b0, timer_clear_out)
		bus(1'b1, OFS_CTRL0, 32'h3);
		@(negedge clock_in);
		`CHECK("start with on", 1'b0, busy_out)
		$display("test trigger done");
	endtask

	// Verdict and end of run
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		srst_in = 1'b1;
		avs_read_in = 1'b0;
		avs_write_in = 1'b0;
		avs_address_in = 8'h00;
		avs_writedata_in = 32'h0;
		strap = 1'b0;
		trigger_in = 1'b0;
		pin_dir = '1;
		level = 10'h000;
		n_mismatch = 0;
		checks = 0;
		cyc = 0;
		t_reset(1'b0);
		t_reset(1'b1);
		t_port();
		// Every clock and acquisition code, both formats, one driven pin
		// 2-cycle period beats comparator sync, drive pin
		for (int i = 0; i < 8; i++) begin
			t_conv(sels[i], 3'(i), i[0], 4'(i), i == 0, 10'(37 + i * 131));
		end
		t_abort();
		t_trig();
		complete_run();
	end
endmodule
